// [src/copper_status_regs.vh]
// register indexes, field positions, reset values for copper status block
`ifndef COPPER_STATUS_REGS_VH
`define COPPER_STATUS_REGS_VH

// register indexes; byte address is four times the index
`define IDX_CONTROL       8'h10
`define IDX_PORT_STATUS   8'h11
`define IDX_IRQ_ENABLE    8'h12
`define IDX_IRQ_STATUS    8'h13
`define IDX_PAIR_POLARITY 8'h14

// port status fields
`define ST_SPEED_HI       15
`define ST_SPEED_LO       14
`define ST_DUPLEX         13
`define ST_PAGE_RX        12
`define ST_RESOLVED       11
`define ST_LINK_RT        10
`define ST_TX_PAUSE       9
`define ST_RX_PAUSE       8
`define ST_MDIX           6
`define ST_SLEEP          4
`define ST_GLOBAL_LINK    3
`define ST_POLARITY       1
`define ST_JABBER         0

// event and enable bit positions
`define EV_AN_ERROR       15
`define EV_SPEED          14
`define EV_DUPLEX         13
`define EV_PAGE_RX        12
`define EV_AN_DONE        11
`define EV_LINK           10
`define EV_SYMBOL         9
`define EV_FALSE_CARRIER  8
`define EV_XOVER          6
`define EV_DOWNSHIFT      5
`define EV_ENERGY         4
`define EV_FLP_NO_LINK    3
`define EV_POLARITY       1
`define EV_JABBER         0

// writable bits of the enable register (bit 2 reserved, reads zero)
`define IRQ_ENABLE_MASK   16'hfffb
`define IRQ_ENABLE_RESET  16'h0000

// control fields
`define CTL_SW_RESET      15
`define CTL_AN_ENABLE     12
`define CTL_XOVER_HI      6
`define CTL_XOVER_LO      5
`define CTL_POL_DISABLE   1

// reset values
`define SPEED_RESET       2'h2
`define XOVER_RESET       2'h3
`define MDIX_RESET        1'h1

// crossover modes and speed codes
`define XOVER_MDI         2'h0
`define XOVER_MDIX        2'h1
`define SPEED_1000        2'h2

`endif

// [src/ahb_reg_slave.v]
// ahb-lite slave front end: one-word single transfers onto a register strobe
module ahb_reg_slave
(
    input  wire        hclk,      // bus clock
    input  wire        hresetn,   // async reset, active low
    input  wire        hsel,      // slave select
    input  wire [31:0] haddr,     // byte address
    input  wire [1:0]  htrans,    // transfer type
    input  wire        hwrite,    // write when high
    input  wire [2:0]  hsize,     // transfer size, word only
    input  wire [31:0] hwdata,    // write data
    input  wire        hready,    // bus ready
    output reg         hreadyout, // slave ready
    output reg         hresp,     // always okay
    output reg  [31:0] hrdata,    // read data
    output wire        wr_stb,    // write strobe, data phase
    output wire        rd_stb,    // read strobe, value captured
    output reg  [7:0]  acc_idx,   // register index of access
    output wire [15:0] wr_data,   // write data, low half
    input  wire [15:0] rd_value   // value of indexed register
);

    reg         wr_pend;
    reg         rd_pend;
    wire        take;

    assign take    = hsel & hready & htrans[1];
    assign wr_stb  = wr_pend;
    assign rd_stb  = rd_pend;
    assign wr_data = hwdata[15:0];

    // reads take one wait state so a write just ahead is already visible
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            acc_idx   <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end
        else if (take)
        begin
            acc_idx   <= haddr[9:2];
            wr_pend   <= hwrite;
            rd_pend   <= ~hwrite;
            hreadyout <= hwrite;
        end
        else
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            if (rd_pend)
            begin
                hrdata    <= {16'h0000, rd_value};
                hreadyout <= 1'b1;
            end
        end
    end

endmodule

// [src/copper_status_irq_enable_regs.v]
// copper port status, event interrupt enable and status registers
//
// Behaviour
// (R1) speed field: 10=1000, 01=100, 00=10 Mbps; resets to 0x2
// (R2) resolved flag set at negotiation done, forced one when negotiation off
// (R3) duplex bit: one full, zero half; valid once resolved
// (R4) page-received bit latches high, clears on read or any reset
// (R5) copper link bit follows the link in real time
// (R6) transmit and receive pause bits report resolution only
// (R7) crossover bit: one MDIX, zero MDI; resets to one; follows manual mode
// (R8) written crossover mode takes effect only at software reset
// (R9) energy-detect bit: one sleep, zero active
// (R10) global link bit reads one while copper link is up
// (R11) real-time polarity, forced normal when reversal is disabled
// (R12) gigabit mode reports each pair's polarity in its own field
// (R13) jabber bit follows jabber detection in real time
// (R14) per-event enable bits, reset zero, kept over software reset
// (R15) negotiation error on role, parallel detect, mode or link failure
// (R16) interrupt high while any enabled latched event is set
`include "copper_status_regs.vh"

module copper_status_irq_enable_regs
(
    input  wire        hclk,         // clock
    input  wire        hresetn,      // async reset, active low
    input  wire        hsel,         // slave select
    input  wire [31:0] haddr,        // byte address
    input  wire [1:0]  htrans,       // transfer type
    input  wire        hwrite,       // write when high
    input  wire [2:0]  hsize,        // transfer size
    input  wire [31:0] hwdata,       // write data
    input  wire        hready,       // bus ready
    output wire        hreadyout,    // slave ready
    output wire        hresp,        // response, always okay
    output wire [31:0] hrdata,       // read data
    input  wire        an_complete,  // negotiation complete, level
    input  wire        page_rx,      // page arrived, pulse
    input  wire [1:0]  res_speed,    // resolved speed
    input  wire        res_duplex,   // resolved duplex
    input  wire        res_tx_pause, // resolved transmit pause
    input  wire        res_rx_pause, // resolved receive pause
    input  wire        link_up,      // copper link, real time
    input  wire        auto_mdix,    // crossover chosen in auto mode
    input  wire        energy_sleep, // port asleep
    input  wire        rx_reversed,  // receive polarity reversed
    input  wire [3:0]  pair_reversed,// per-pair polarity
    input  wire        jabber_det,   // jabber detected
    input  wire        ms_fault,     // master/slave unresolved, pulse
    input  wire        pd_fault,     // parallel detect fault, pulse
    input  wire        no_hcd,       // no common mode, pulse
    input  wire        symbol_err,   // symbol error, pulse
    input  wire        false_carrier,// false carrier, pulse
    input  wire        downshift,    // downshift, pulse
    input  wire        flp_no_link,  // flp done but no link, pulse
    output reg         irq,          // interrupt, level, active high
    output reg  [1:0]  xover_mode,   // crossover mode in force
    output reg         sw_reset      // software reset pulse
);

    ////////////////////////////////////////////////////////////////////
    // bus front end

    wire        wr_stb;
    wire        rd_stb;
    wire [7:0]  acc_idx;
    wire [15:0] wr_data;
    reg  [15:0] rd_value;

    ahb_reg_slave u_bus
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .wr_stb    (wr_stb),
        .rd_stb    (rd_stb),
        .acc_idx   (acc_idx),
        .wr_data   (wr_data),
        .rd_value  (rd_value)
    );

    function hit;
        input [7:0] idx;
        input [7:0] want;
        input       stb;
        begin
            hit = stb & (idx == want);
        end
    endfunction

    wire wr_ctl;
    wire wr_en;
    wire wr_ist;
    wire rd_st;

    assign wr_ctl = hit(acc_idx, `IDX_CONTROL, wr_stb);
    assign wr_en  = hit(acc_idx, `IDX_IRQ_ENABLE, wr_stb);
    assign wr_ist = hit(acc_idx, `IDX_IRQ_STATUS, wr_stb);
    assign rd_st  = hit(acc_idx, `IDX_PORT_STATUS, rd_stb);

    ////////////////////////////////////////////////////////////////////
    // control register

    reg        an_enable;
    reg  [1:0] xover_cfg;
    reg        pol_disable;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            an_enable   <= 1'b1;
            xover_cfg   <= `XOVER_RESET;
            pol_disable <= 1'b0;
            sw_reset    <= 1'b0;
        end
        else
        begin
            sw_reset <= wr_ctl & wr_data[`CTL_SW_RESET];
            if (wr_ctl)
            begin
                an_enable   <= wr_data[`CTL_AN_ENABLE];
                xover_cfg   <= wr_data[`CTL_XOVER_HI:`CTL_XOVER_LO];
                pol_disable <= wr_data[`CTL_POL_DISABLE];
            end
        end
    end

    // (R8) apply at reset
    // disruptive to the link, so a plain write only stages the value
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            xover_mode <= `XOVER_RESET;
        else if (sw_reset)
            xover_mode <= xover_cfg;
    end

    ////////////////////////////////////////////////////////////////////
    // port status register

    reg  [1:0] speed;
    reg        duplex;
    reg        page_seen;
    reg        resolved;
    reg        link_rt;
    reg        tx_pause;
    reg        rx_pause;
    reg        mdix;
    reg        sleep;
    reg        polarity;
    reg  [3:0] pair_pol;
    reg        jabber;
    reg        next_mdix;

    // (R7) manual mode follows config
    always @*
    begin
        case (xover_mode)
            `XOVER_MDI:  next_mdix = 1'b0;
            `XOVER_MDIX: next_mdix = 1'b1;
            default:     next_mdix = auto_mdix;
        endcase
    end

    // fields retained over software reset
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            speed  <= `SPEED_RESET;
            duplex <= 1'b0;
            mdix   <= `MDIX_RESET;
        end
        else
        begin
            // (R1) speed field
            speed  <= res_speed;
            // (R3) duplex bit
            duplex <= res_duplex;
            mdix   <= next_mdix;
        end
    end

    // fields that clear on software reset
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            page_seen <= 1'b0;
            resolved  <= 1'b0;
            link_rt   <= 1'b0;
            tx_pause  <= 1'b0;
            rx_pause  <= 1'b0;
            sleep     <= 1'b0;
            polarity  <= 1'b0;
            pair_pol  <= 4'h0;
            jabber    <= 1'b0;
        end
        else if (sw_reset)
        begin
            page_seen <= 1'b0;
            resolved  <= 1'b0;
            link_rt   <= 1'b0;
            tx_pause  <= 1'b0;
            rx_pause  <= 1'b0;
            sleep     <= 1'b0;
            polarity  <= 1'b0;
            pair_pol  <= 4'h0;
            jabber    <= 1'b0;
        end
        else
        begin
            // (R4) latch, set beats read clear
            page_seen <= page_rx | (page_seen & ~rd_st);
            // (R2) resolved flag
            resolved  <= ~an_enable | an_complete;
            // (R5) real-time link
            link_rt   <= link_up;
            // (R6) pause report only
            tx_pause  <= res_tx_pause;
            rx_pause  <= res_rx_pause;
            // (R9) energy detect
            sleep     <= energy_sleep;
            // (R11) forced normal
            polarity  <= rx_reversed & ~pol_disable;
            // (R12) per-pair polarity
            pair_pol  <= (res_speed == `SPEED_1000) ? pair_reversed : 4'h0;
            // (R13) real-time jabber
            jabber    <= jabber_det;
        end
    end

    wire [15:0] port_status;

    // (R10) global link bit
    assign port_status = {speed, duplex, page_seen, resolved, link_rt,
                          tx_pause, rx_pause, 1'b0, mdix, 1'b0, sleep,
                          link_rt, 1'b0, polarity, jabber};

    ////////////////////////////////////////////////////////////////////
    // event detection

    reg  [15:0] prev;
    reg  [15:0] events;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            prev <= {`SPEED_RESET, 7'h00, `MDIX_RESET, 6'h00};
        else
            prev <= port_status;
    end

    function changed;
        input [15:0] now;
        input [15:0] was;
        input integer pos;
        begin
            changed = now[pos] ^ was[pos];
        end
    endfunction

    always @*
    begin
        events = 16'h0000;
        // (R15) negotiation error
        events[`EV_AN_ERROR] = ms_fault | pd_fault | no_hcd |
                               (resolved & an_enable & ~link_rt &
                                ~prev[`ST_RESOLVED]);
        events[`EV_SPEED] = resolved & (speed != prev[15:14]);
        events[`EV_DUPLEX] = resolved &
                             changed(port_status, prev, `ST_DUPLEX);
        events[`EV_PAGE_RX] = page_rx;
        events[`EV_AN_DONE] = resolved & an_enable & ~prev[`ST_RESOLVED];
        events[`EV_LINK] = changed(port_status, prev, `ST_LINK_RT);
        events[`EV_SYMBOL] = symbol_err;
        events[`EV_FALSE_CARRIER] = false_carrier;
        events[`EV_XOVER] = changed(port_status, prev, `ST_MDIX);
        events[`EV_DOWNSHIFT] = downshift;
        events[`EV_ENERGY] = changed(port_status, prev, `ST_SLEEP);
        events[`EV_FLP_NO_LINK] = flp_no_link;
        events[`EV_POLARITY] = changed(port_status, prev, `ST_POLARITY);
        events[`EV_JABBER] = jabber & ~prev[`ST_JABBER];
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt enable and latched event status

    reg  [15:0] irq_enable;
    reg  [15:0] irq_status;

    // (R14) enables survive software reset
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_enable <= `IRQ_ENABLE_RESET;
        else if (wr_en)
            irq_enable <= wr_data & `IRQ_ENABLE_MASK;
    end

    // write one to clear; a new event in the same cycle stays set
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_status <= 16'h0000;
        else if (sw_reset)
            irq_status <= 16'h0000;
        else if (wr_ist)
            irq_status <= events | (irq_status & ~wr_data);
        else
            irq_status <= events | irq_status;
    end

    // (R16) interrupt output
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq <= 1'b0;
        else
            irq <= |(irq_status & irq_enable);
    end

    ////////////////////////////////////////////////////////////////////
    // read mux

    always @*
    begin
        case (acc_idx)
            `IDX_CONTROL:
                rd_value = {3'h0, an_enable, 5'h00, xover_cfg, 3'h0,
                            pol_disable, 1'b0};
            `IDX_PORT_STATUS:   rd_value = port_status;
            `IDX_IRQ_ENABLE:    rd_value = irq_enable;
            `IDX_IRQ_STATUS:    rd_value = irq_status;
            `IDX_PAIR_POLARITY: rd_value = {12'h000, pair_pol};
            default:            rd_value = 16'h0000;
        endcase
    end

endmodule

// [sim/copper_regs_sva.sv]
// assertion checker for the copper status register block
module copper_regs_sva
(
    input wire logic        hclk,       // clock
    input wire logic        hresetn,    // reset, active low
    input wire logic        hsel,       // select
    input wire logic [1:0]  htrans,     // transfer type
    input wire logic        hwrite,     // write
    input wire logic        hready,     // bus ready
    input wire logic        hreadyout,  // slave ready
    input wire logic        hresp,      // response
    input wire logic [31:0] hrdata,     // read data
    input wire logic        irq,        // interrupt
    input wire logic [1:0]  xover_mode, // crossover in force
    input wire logic        sw_reset    // software reset
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire take = hsel & hready & htrans[1];
    ////////////////////////////////////////////////////////////
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("bad response");
    property p_upper; hrdata[31:16] == 16'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper data");
    property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait");
    property p_wr_nowait; take && hwrite |=> hreadyout; endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("wr wait");
    property p_idle; !hreadyout |-> $past(take && !hwrite); endproperty
    a_idle: assert property (p_idle) else $error("stray wait");
    property p_hold; !$rose(hreadyout) |-> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("data moved");
    property p_sw_pulse; sw_reset |=> !sw_reset; endproperty
    a_sw_pulse: assert property (p_sw_pulse) else $error("long pulse");
    // crossover only moves around a software reset
    property p_xover;
        !$stable(xover_mode) |-> sw_reset || $past(sw_reset);
    endproperty
    a_xover: assert property (p_xover) else $error("xover moved");
    c_read: cover property (take && !hwrite);
    c_sw: cover property (sw_reset);
    c_irq: cover property ($rose(irq));
endmodule

bind copper_status_irq_enable_regs copper_regs_sva chk (.*);

// [sim/tb_top.sv]
// self-checking bench for the copper status register block
`include "copper_status_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, hsel, hwrite, page_rx;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata;
    logic [3:0]  pair_reversed;
    logic [10:0] st;
    logic [6:0]  pulses;
    logic [15:0] rv;
    wire         hready, hreadyout, hresp, irq, sw_reset;
    wire  [31:0] hrdata;
    wire  [1:0]  xover_mode, res_speed;
    wire         an_complete, res_duplex, res_tx_pause, res_rx_pause;
    wire         link_up, auto_mdix, energy_sleep, rx_reversed;
    wire         jabber_det, ms_fault, pd_fault, no_hcd, symbol_err;
    wire         false_carrier, downshift, flp_no_link;
    int          err_total, checks;
    int          cyc = 0;
    int          evpos [7] = '{15, 15, 15, 9, 8, 5, 3};
    // status inputs beside the port status they should give
    logic [26:0] rows [4] = '{{11'h000, 16'h0000}, {11'h6d8, 16'hae48},
                              {11'h527, 16'h4913}, {11'h070, 16'h0708}};
    assign hready = hreadyout;
    assign {an_complete, res_speed, res_duplex, res_tx_pause,
            res_rx_pause, link_up, auto_mdix, energy_sleep,
            rx_reversed, jabber_det} = st;
    assign {ms_fault, pd_fault, no_hcd, symbol_err, false_carrier,
            downshift, flp_no_link} = pulses;
    copper_status_irq_enable_regs uut (.*);
    ////////////////////////////////////////////////////////////
    initial hclk = 1'b0;
    always #4 hclk = ~hclk;
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // entered just after a rising edge; waits out any wait state
    task automatic bus(input logic [7:0] idx, input logic wr,
                       input logic [15:0] wd);
        htrans <= 2'h2;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {16'h0, wd};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rv = hrdata[15:0];
    endtask
    task automatic wr(input logic [7:0] idx, input logic [15:0] wd);
        bus(idx, 1'b1, wd);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [15:0] exp);
        bus(idx, 1'b0, 16'h0);
        chk(rv, exp);
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b1;
        hsize = 3'h2;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        page_rx = 1'b0;
        pair_reversed = 4'h0;
        pulses = 7'h0;
        st = 11'h208;
        err_total = 0;
        checks = 0;
        tick(3);
        hresetn <= 1'b1;
        tick(1);
        chk(16'(xover_mode), 16'h3);
        rdc(`IDX_PORT_STATUS, 16'h8040);
        rdc(`IDX_IRQ_ENABLE, `IRQ_ENABLE_RESET);
        $display("reset values done");
        foreach (rows[i])
        begin
            st <= rows[i][26:16];
            tick(3);
            rdc(`IDX_PORT_STATUS, rows[i][15:0]);
            chk(16'(irq), 16'h0);
        end
        $display("status rows done");
        wr(`IDX_IRQ_STATUS, 16'hffff);
        wr(`IDX_IRQ_ENABLE, 16'hffff);
        rdc(`IDX_IRQ_ENABLE, `IRQ_ENABLE_MASK);
        wr(8'h30, 16'hffff);
        rdc(8'h30, 16'h0000);
        foreach (evpos[k])
        begin
            pulses <= 7'h40 >> k;
            tick(1);
            pulses <= 7'h0;
            tick(3);
            chk(16'(irq), 16'h1);
            rdc(`IDX_IRQ_STATUS, 16'h1 << evpos[k]);
            wr(`IDX_IRQ_STATUS, 16'hffff);
            tick(2);
            chk(16'(irq), 16'h0);
        end
        $display("event sources done");
        wr(`IDX_IRQ_ENABLE, 16'h0001);
        st[0] <= 1'b1;
        tick(4);
        chk(16'(irq), 16'h1);
        wr(`IDX_IRQ_ENABLE, 16'h0000);
        tick(2);
        chk(16'(irq), 16'h0);
        wr(`IDX_IRQ_ENABLE, 16'h0001);
        tick(2);
        chk(16'(irq), 16'h1);
        wr(`IDX_IRQ_STATUS, 16'h0001);
        tick(2);
        chk(16'(irq), 16'h0);
        $display("interrupt mask done");
        page_rx <= 1'b1;
        tick(1);
        page_rx <= 1'b0;
        tick(2);
        rdc(`IDX_PORT_STATUS, 16'h1709);
        rdc(`IDX_PORT_STATUS, 16'h0709);
        // negotiation off forces resolved; polarity held normal
        wr(`IDX_CONTROL, 16'h0062);
        st[1] <= 1'b1;
        tick(3);
        rdc(`IDX_PORT_STATUS, 16'h0f09);
        wr(`IDX_CONTROL, 16'h0060);
        tick(3);
        rdc(`IDX_PORT_STATUS, 16'h0f0b);
        rdc(`IDX_CONTROL, 16'h0060);
        // staged crossover waits for software reset
        wr(`IDX_CONTROL, 16'h0020);
        tick(3);
        chk(16'(xover_mode), 16'h3);
        rdc(`IDX_PORT_STATUS, 16'h0f0b);
        wr(`IDX_CONTROL, 16'h8020);
        tick(1);
        chk(16'(sw_reset), 16'h1);
        tick(2);
        chk(16'(xover_mode), 16'h1);
        rdc(`IDX_PORT_STATUS, 16'h0f4b);
        rdc(`IDX_IRQ_ENABLE, 16'h0001);
        wr(`IDX_CONTROL, 16'h8000);
        tick(3);
        chk(16'(xover_mode), 16'h0);
        // per-pair polarity only at gigabit speed
        st[9:8] <= 2'h2;
        pair_reversed <= 4'h9;
        tick(3);
        rdc(`IDX_PAIR_POLARITY, 16'h0009);
        st[9:8] <= 2'h0;
        tick(3);
        rdc(`IDX_PAIR_POLARITY, 16'h0000);
        $display("control cases done");
        hresetn <= 1'b0;
        tick(2);
        hresetn <= 1'b1;
        tick(1);
        chk(16'(xover_mode), 16'h3);
        rdc(`IDX_IRQ_ENABLE, `IRQ_ENABLE_RESET);
        $display("second reset done");
        finish_test();
    end
endmodule
